// file: hw/ptr_telemetry.sv
`timescale 1ns/1ns
// How it works
// RULE1: Channel-four current readable at command 3Ch.
// RULE2: Low byte sent first, high byte second.
// RULE3: 14-bit result, top two bits zero, reset zero.
// RULE4: Powered current refreshed every 100 ms.
// RULE5: Host scales current by 89.5 uA/count.
// RULE6: Class current held until powered reading, disable.
// RULE7: Host scales class current by 8.95 uA.
// RULE8: Foldback turns channel off above doubled threshold.
// RULE9: Channel 1-3 voltages at 32h, 36h, 3Ah.
// RULE10: Host scales voltage by 3.662 mV/count.
// RULE11: Voltage of an off channel reads zero.
// RULE12: Writes to these registers are ignored.
module ptr_telemetry
   import ptr_pkg::*;
#(
   parameter int REFRESH_CYC = PTR_REFRESH_CYC
) (
   // Clock and reset.
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   // Converter results and strobes from the measurement engine.
   input  wire logic [13:0] i_amp_code,
   input  wire logic        i_amp_done,
   input  wire logic [13:0] i_class_code,
   input  wire logic        i_class_done,
   input  wire logic [13:0] i_volt1_code,
   input  wire logic [13:0] i_volt2_code,
   input  wire logic [13:0] i_volt3_code,
   input  wire logic        i_volt_done,
   // Channel state.
   input  wire logic [3:0]  i_chan_on,
   input  wire logic        i_port4_disable,
   input  wire logic        i_over_doubled_limit,
   // Serial-side register access.
   input  wire logic [7:0]  i_cmd,
   input  wire logic        i_cmd_load,
   input  wire logic        i_byte_rd,
   input  wire logic        i_wr,
   // Outputs.
   output logic [7:0]       o_rd_byte,
   output logic             o_cmd_hit,
   output logic             o_amp_is_class,
   output logic             o_amp_sample,
   output logic             o_port4_off
);

   // Pads a 14-bit conversion result into the two-byte register image.
   function automatic logic [15:0] ptr_word(input logic [13:0] code);
      ptr_word = {2'b00, code}; // [RULE3]
   endfunction

   // Off channels one to three read zero no matter what the converter last held.
   function automatic logic [15:0] ptr_gate(input logic on, input logic [13:0] code);
      ptr_gate = on ? ptr_word(code) : 16'h0000; // [RULE11]
   endfunction

   // Channel-four current result and its class marker.
   logic [13:0] amp_q;
   logic [13:0] amp_d;
   logic        is_class_q;
   logic        is_class_d;
   // Voltage results of channels one to three.
   logic [13:0] v1_q;
   logic [13:0] v1_d;
   logic [13:0] v2_q;
   logic [13:0] v2_d;
   logic [13:0] v3_q;
   logic [13:0] v3_d;
   // Refresh timer, foldback latch and refresh pulse.
   logic [31:0] tick_q;
   logic [31:0] tick_d;
   logic        off_q;
   logic        off_d;
   logic        sample_q;
   logic        sample_d;
   // Serial-side selection and byte pointer.
   logic [7:0]  cmd_q;
   logic [7:0]  cmd_d;
   logic        hit_q;
   logic        hit_d;
   logic        byte_sel_q;
   logic        byte_sel_d;
   logic [7:0]  rd_byte_q;
   logic [7:0]  rd_byte_d;
   logic [15:0] sel_word;

   // The timer only runs while channel four is powered and not folded back.
   wire         tick_end   = (tick_q >= 32'(REFRESH_CYC - 1));
   wire         powered4   = i_chan_on[3] && !off_q;
   wire         amp_take   = tick_end && powered4 && i_amp_done; // [RULE4]
   // A write is dropped entirely; it neither selects nor alters a result.
   wire         cmd_take   = i_cmd_load && !i_wr; // [RULE12]
   wire         byte_take  = i_byte_rd && !cmd_take;
   wire         hit_ch4    = (i_cmd == PTR_CMD_CH4_AMP); // [RULE1]
   wire         hit_volt   = (i_cmd == PTR_CMD_CH1_VOLT) || (i_cmd == PTR_CMD_CH2_VOLT)
                             || (i_cmd == PTR_CMD_CH3_VOLT); // [RULE9]
   wire [15:0]  v1_word    = ptr_gate(i_chan_on[0], v1_q); // [RULE11]
   wire [15:0]  v2_word    = ptr_gate(i_chan_on[1], v2_q); // [RULE11]
   wire [15:0]  v3_word    = ptr_gate(i_chan_on[2], v3_q); // [RULE11]
   wire [15:0]  amp_word   = ptr_word(amp_q);
   always_comb begin
      case (cmd_q)
         PTR_CMD_CH1_VOLT: sel_word = v1_word;
         PTR_CMD_CH2_VOLT: sel_word = v2_word;
         PTR_CMD_CH3_VOLT: sel_word = v3_word;
         PTR_CMD_CH4_AMP:  sel_word = amp_word;
         default:          sel_word = 16'h0000;
      endcase
   end
   wire [7:0]   next_byte  = (byte_sel_q == PTR_BYTE_LOW) ? sel_word[7:0] : sel_word[15:8]; // [RULE2]

   // Class result wins over a same-cycle powered result; disable clears both.
   assign tick_d     = (!powered4 || amp_take) ? 32'd0 : tick_q + 32'd1; // [RULE4]
   assign amp_d      = i_port4_disable ? PTR_CODE_RESET :
                       i_class_done    ? i_class_code   : // [RULE6]
                       amp_take        ? i_amp_code     : // [RULE4]
                                         amp_q;
   assign is_class_d = i_port4_disable ? 1'b0 :
                       i_class_done    ? 1'b1 :           // [RULE6]
                       amp_take        ? 1'b0 :           // [RULE6]
                                         is_class_q;
   assign v1_d       = i_volt_done ? i_volt1_code : v1_q;
   assign v2_d       = i_volt_done ? i_volt2_code : v2_q;
   assign v3_d       = i_volt_done ? i_volt3_code : v3_q;
   // Foldback latches the channel off until it is disabled or switched off.
   assign off_d      = i_chan_on[3] && !i_port4_disable && (off_q || i_over_doubled_limit); // [RULE8]
   assign sample_d   = amp_take;
   assign cmd_d      = cmd_take ? i_cmd : cmd_q;
   assign hit_d      = cmd_take ? (hit_ch4 || hit_volt) : hit_q;
   // A new selection always restarts at the low byte.
   assign byte_sel_d = cmd_take ? PTR_BYTE_LOW : (byte_take ? ~byte_sel_q : byte_sel_q); // [RULE2]
   assign rd_byte_d  = byte_take ? next_byte : rd_byte_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         amp_q      <= PTR_CODE_RESET; // [RULE3]
         is_class_q <= 1'b0;
      end else begin
         amp_q      <= amp_d;
         is_class_q <= is_class_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         v1_q <= PTR_CODE_RESET; // [RULE3]
      end else begin
         v1_q <= v1_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         v2_q <= PTR_CODE_RESET; // [RULE3]
      end else begin
         v2_q <= v2_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         v3_q <= PTR_CODE_RESET; // [RULE3]
      end else begin
         v3_q <= v3_d;
      end
   end

   // The timer is 32 bits wide so the full refresh span fits with room to spare.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         tick_q <= 32'd0;
      end else begin
         tick_q <= tick_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         off_q <= 1'b0;
      end else begin
         off_q <= off_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sample_q <= 1'b0;
      end else begin
         sample_q <= sample_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cmd_q <= 8'h00;
         hit_q <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         hit_q <= hit_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         byte_sel_q <= PTR_BYTE_LOW;
      end else begin
         byte_sel_q <= byte_sel_d;
      end
   end

   // The fetched byte stands until the next fetch, so the host may take it late.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rd_byte_q <= PTR_BYTE_IDLE;
      end else begin
         rd_byte_q <= rd_byte_d;
      end
   end

   assign o_rd_byte      = rd_byte_q;
   assign o_cmd_hit      = hit_q;
   assign o_amp_is_class = is_class_q; // [RULE7]
   assign o_amp_sample   = sample_q;
   assign o_port4_off    = off_q;
endmodule

// file: hw/ptr_pkg.sv
package ptr_pkg;
   // Command codes of the telemetry registers.
   localparam logic [7:0]  PTR_CMD_CH1_VOLT = 8'h32;
   localparam logic [7:0]  PTR_CMD_CH2_VOLT = 8'h36;
   localparam logic [7:0]  PTR_CMD_CH3_VOLT = 8'h3A;
   localparam logic [7:0]  PTR_CMD_CH4_AMP  = 8'h3C;
   // Field layout and reset value.
   localparam int          PTR_CODE_W       = 14;
   localparam int          PTR_CODE_MSB     = 13;
   localparam logic [13:0] PTR_CODE_RESET   = 14'h0000;
   localparam logic [7:0]  PTR_BYTE_IDLE    = 8'h00;
   // Refresh interval of the powered current result.
   localparam int          PTR_CLK_HZ       = 10_000_000;
   localparam int          PTR_REFRESH_MS   = 100;
   localparam int          PTR_REFRESH_CYC  = (PTR_CLK_HZ / 1000) * PTR_REFRESH_MS;
   localparam logic [0:0]  PTR_BYTE_LOW     = 1'b0;
   localparam logic [0:0]  PTR_BYTE_HIGH    = 1'b1;
endpackage

// file: verif/ptr_telemetry_asserts.sv
`timescale 1ns/1ns
module ptr_telemetry_asserts (
   input wire logic       i_clk, i_reset, i_cmd_load, i_byte_rd, i_wr, i_class_done,
   input wire logic       i_port4_disable, i_over_doubled_limit, o_cmd_hit, o_amp_is_class,
   input wire logic       o_amp_sample, o_port4_off,
   input wire logic [7:0] i_cmd, o_rd_byte,
   input wire logic [3:0] i_chan_on
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   a_cmd_hit_map: assert property (i_cmd_load && !i_wr |=>
      o_cmd_hit == ($past(i_cmd) inside {8'h32, 8'h36, 8'h3A, 8'h3C})) else $error("bad hit");
   a_write_no_effect: assert property (i_cmd_load && i_wr |=> $stable(o_cmd_hit)) else $error("write acted");
   a_reset_clears: assert property (disable iff (1'b0) i_reset |=> o_rd_byte == 8'h00 && !o_amp_is_class)
      else $error("reset value");
   a_sample_spacing: assert property (o_amp_sample |=> !o_amp_sample [*7]) else $error("refresh fast");
   a_byte_holds: assert property (!i_byte_rd |=> $stable(o_rd_byte)) else $error("byte moved");
   a_foldback_off: assert property (i_over_doubled_limit && i_chan_on[3] && !i_port4_disable |=> o_port4_off)
      else $error("no foldback");
   a_class_shown: assert property (i_class_done |=> o_amp_is_class) else $error("class lost");
   a_disable_drops: assert property (i_port4_disable && !i_class_done |=> !o_amp_is_class) else $error("class kept");
endmodule

// file: verif/ptr_host_model.sv
`timescale 1ns/1ns
module ptr_host_model (
   input  wire logic [7:0] i_rd_byte,
   input  wire logic       i_clk,
   output logic [7:0]      o_cmd,
   output logic            o_cmd_load,
   output logic            o_byte_rd,
   output logic            o_wr
);
   initial {o_cmd, o_cmd_load, o_byte_rd, o_wr} = '0;
   // Each result is assembled from two back-to-back fetches; a refresh between them can still split it.
   task automatic rd(input logic [7:0] cmd, output logic [15:0] val);
      @(negedge i_clk) {o_cmd, o_cmd_load} = {cmd, 1'b1};
      @(negedge i_clk) {o_cmd_load, o_byte_rd} = 2'b01;
      @(negedge i_clk) val[7:0] = i_rd_byte;
      @(negedge i_clk) val[15:8] = i_rd_byte;
      o_byte_rd = 1'b0;
   endtask
   task automatic wr(input logic [7:0] cmd);
      @(negedge i_clk) {o_cmd, o_cmd_load, o_wr} = {cmd, 2'b11};
      @(negedge i_clk) {o_cmd_load, o_wr} = 2'b00;
   endtask
   // Host-side scaling in whole nano-amps and micro-volts, so no fractions are needed.
   function automatic longint amp_na(input logic [15:0] word, input logic is_class);
      if (is_class) begin
         amp_na = longint'(word[13:0]) * 8950;
      end else begin
         amp_na = longint'(word[13:0]) * 89500;
      end
   endfunction
   function automatic longint volt_uv(input logic [15:0] word);
      volt_uv = longint'(word[13:0]) * 3662;
   endfunction
endmodule

// file: verif/ptr_telemetry_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; $display("unexpected t=%0t %h %h", $time, a, e); end end
module ptr_telemetry_tb;
   logic        i_clk = 0, i_reset = 1, i_amp_done = 0, i_class_done = 0, i_volt_done = 0;
   logic        i_port4_disable = 0, i_over_doubled_limit = 0, i_cmd_load, i_byte_rd, i_wr;
   logic        o_cmd_hit, o_amp_is_class, o_amp_sample, o_port4_off;
   logic [13:0] i_amp_code = 14'h0ABC, i_class_code = 14'h0155, i_volt1_code = 14'h3FFF;
   logic [13:0] i_volt2_code = 14'h1234, i_volt3_code = 14'h2ABC;
   logic [3:0]  i_chan_on = 4'h0;
   logic [7:0]  i_cmd, o_rd_byte;
   logic [15:0] v;
   int          n_errors = 0, checked = 0;
   // Each row: hit flag, command, channels on, expected word.
   logic [28:0] rows [5] = '{29'h13213FFF, 29'h13621234, 29'h13A42ABC, 29'h13A00000, 29'h03EF0000};
   ptr_telemetry #(.REFRESH_CYC(8)) ptr_telemetry_i (.i_clk, .i_reset, .i_amp_code, .i_amp_done, .i_class_code,
      .i_class_done, .i_volt1_code, .i_volt2_code, .i_volt3_code, .i_volt_done, .i_chan_on, .i_port4_disable,
      .i_over_doubled_limit, .i_cmd, .i_cmd_load, .i_byte_rd, .i_wr, .o_rd_byte, .o_cmd_hit, .o_amp_is_class,
      .o_amp_sample, .o_port4_off);
   ptr_host_model ptr_host_model_i (.i_rd_byte(o_rd_byte), .i_clk, .o_cmd(i_cmd), .o_cmd_load(i_cmd_load),
      .o_byte_rd(i_byte_rd), .o_wr(i_wr));
   always #50 i_clk = ~i_clk;
   task automatic close_out;
      $display("n_errors=%0d checked=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #100000 n_errors++;
      close_out();
   end
   initial begin
      repeat (2) @(negedge i_clk);
      i_reset = 0;
      ptr_host_model_i.rd(8'h3C, v); `CHK(v, 16'h0000)
      @(negedge i_clk) i_volt_done = 1;
      @(negedge i_clk) i_volt_done = 0;
      foreach (rows[k]) begin
         i_chan_on = rows[k][19:16];
         ptr_host_model_i.rd(rows[k][27:20], v); `CHK(v, rows[k][15:0])
         `CHK(o_cmd_hit, rows[k][28])
      end
      ptr_host_model_i.rd(8'h32, v); `CHK(ptr_host_model_i.volt_uv(v), 64'd59994546)
      @(negedge i_clk) i_class_done = 1;
      @(negedge i_clk) i_class_done = 0;
      ptr_host_model_i.rd(8'h3C, v); `CHK({v, o_amp_is_class}, 17'h002AB)
      `CHK(ptr_host_model_i.amp_na(v, o_amp_is_class), 64'd3051950)
      {i_amp_done, i_chan_on} = 5'h18;
      for (int k = 0; k < 20 && o_amp_sample !== 1'b1; k++) @(negedge i_clk);
      `CHK(o_amp_sample, 1'b1)
      i_amp_done = 0;
      ptr_host_model_i.wr(8'h3E);
      `CHK(o_cmd_hit, 1'b1)
      ptr_host_model_i.rd(8'h3C, v); `CHK({v, o_amp_is_class}, 17'h01578)
      `CHK(ptr_host_model_i.amp_na(v, o_amp_is_class), 64'd245946000)
      i_over_doubled_limit = 1;
      repeat (2) @(negedge i_clk);
      `CHK(o_port4_off, 1'b1)
      {i_over_doubled_limit, i_chan_on, i_port4_disable} = 6'h01;
      @(negedge i_clk) i_port4_disable = 0;
      ptr_host_model_i.rd(8'h3C, v); `CHK(v, 16'h0000)
      @(negedge i_clk) i_class_done = 1;
      @(negedge i_clk) {i_class_done, i_reset} = 2'b01;
      repeat (2) @(negedge i_clk);
      {i_reset, i_chan_on} = 5'h01;
      `CHK({o_amp_is_class, o_cmd_hit, o_rd_byte}, 10'h000)
      ptr_host_model_i.rd(8'h32, v); `CHK(v, 16'h0000)
      close_out();
   end
endmodule
bind ptr_telemetry ptr_telemetry_asserts ptr_telemetry_asserts_i (.i_clk, .i_reset, .i_cmd_load, .i_byte_rd, .i_wr,
   .i_class_done, .i_port4_disable, .i_over_doubled_limit, .o_cmd_hit, .o_amp_is_class, .o_amp_sample,
   .o_port4_off, .i_cmd, .o_rd_byte, .i_chan_on);
